//--- src/wcc_ctrl.sv
// Wake source and cyclic timer control registers behind the serial port.
// Assumes mode events arrive as one-cycle pulses on i_clk and pin levels
// come already synchronised from the comparators.
`default_nettype none

module wcc_ctrl
   import wcc_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_csn,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe,
   input wire logic i_fail_output,
   input wire logic i_stop_to_normal,
   input wire logic i_failsafe_entry,
   input wire logic i_normal_mode,
   input wire logic i_wake_event,
   input wire logic i_status_event,
   input wire logic i_wake_pin_level,
   input wire logic i_gpio_pin_level,
   input wire logic i_gpio_is_wake,
   output logic o_timer_wake_enable,
   output logic o_stop_watchdog_off_b1,
   output logic o_int_global,
   output logic o_wake_pin_sense_select,
   output logic o_wake_pin_wake_en,
   output logic o_gpio_cfg_ignored,
   output logic o_meas_enable,
   output logic o_wake_pin_level,
   output logic o_gpio_pin_level,
   output logic o_irq_out_n,
   output logic [1:0] o_wake_pin_pull_cfg,
   output logic [1:0] o_gpio_wake_pull_cfg,
   output logic o_bus_fast_mode,
   output logic o_spi_fail,
   output logic o_high_side_out,
   output logic o_timer_wake,
   output logic o_timer_running
);

   logic [7:0] internal_wake_ctrl;
   logic [7:0] external_wake_ctrl;
   logic [7:0] wake_pull_ctrl;
   logic [7:0] bus_fast_mode_ctrl;
   logic [7:0] cyclic_timer_ctrl;
   logic [6:0] addr;
   logic wr_stb;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic timer_cfg_stb;
   logic cycle_start;

   wcc_spi i_wcc_spi (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sclk(i_sclk),
      .i_csn(i_csn),
      .i_sdi(i_sdi),
      .i_rd_data(rd_data),
      .o_sdo(o_sdo),
      .o_sdo_oe(o_sdo_oe),
      .o_addr(addr),
      .o_wr_stb(wr_stb),
      .o_wr_data(wr_data)
   );

   wire sense = external_wake_ctrl[B_SENSE];
   wire wr_int = wr_stb && addr == ADDR_INT_WAKE;
   wire wr_ext = wr_stb && addr == ADDR_EXT_WAKE;
   wire wr_tmr = wr_stb && addr == ADDR_TIMER;
   wire ext_refused = wr_ext && wr_data[B_SENSE] && i_fail_output;
   wire tmr_refused = wr_tmr && wr_data[6:4] == ON_RSVD;

   // Read-back: registers already hold zero in reserved bits
   always_comb begin
      case (addr)
         ADDR_INT_WAKE: rd_data = internal_wake_ctrl;
         ADDR_EXT_WAKE: rd_data = external_wake_ctrl;
         ADDR_PULL: rd_data = wake_pull_ctrl;
         ADDR_BUS_FAST: rd_data = bus_fast_mode_ctrl;
         ADDR_TIMER: rd_data = cyclic_timer_ctrl;
         default: rd_data = 8'h00;
      endcase
   end

   // A software write in the same cycle as the mode change wins,
   // so a freshly written value is never silently lost.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         internal_wake_ctrl <= RST_INT_WAKE;
      end else if (wr_int) begin
         internal_wake_ctrl <= wr_data & MASK_INT_WAKE;
      end else if (i_stop_to_normal) begin
         internal_wake_ctrl[B_STOP_WD_OFF] <= 1'b0;
      end
   end

   // Fail-safe forcing outranks a write landing in the same cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         external_wake_ctrl <= RST_EXT_WAKE;
      end else if (i_failsafe_entry) begin
         if (!sense) begin
            external_wake_ctrl <= (external_wake_ctrl & FAILSAFE_KEEP) | FAILSAFE_SET;
         end
      end else if (wr_ext && !ext_refused) begin
         external_wake_ctrl <= wr_data & MASK_EXT_WAKE;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_spi_fail <= 1'b0;
      end else begin
         o_spi_fail <= ext_refused;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wake_pull_ctrl <= RST_PULL;
         bus_fast_mode_ctrl <= RST_BUS_FAST;
      end else if (wr_stb) begin
         if (addr == ADDR_PULL) wake_pull_ctrl <= wr_data & MASK_PULL;
         if (addr == ADDR_BUS_FAST) bus_fast_mode_ctrl <= wr_data & MASK_BUS_FAST;
      end
   end

   // Reserved on-time code is dropped whole rather than half applied
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cyclic_timer_ctrl <= RST_TIMER;
         timer_cfg_stb <= 1'b0;
      end else begin
         timer_cfg_stb <= wr_tmr && !tmr_refused;
         if (wr_tmr && !tmr_refused) begin
            cyclic_timer_ctrl <= wr_data & MASK_TIMER;
         end
      end
   end

   wcc_timer #(
      .TICK_CNT(TICK_CNT)
   ) i_wcc_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_on_code(cyclic_timer_ctrl[B_ON_TIME +: 3]),
      .i_per_code(cyclic_timer_ctrl[B_PERIOD +: 4]),
      .i_cfg_stb(timer_cfg_stb),
      .o_high_side_out(o_high_side_out),
      .o_cycle_start(cycle_start),
      .o_running(o_timer_running)
   );

   // Outputs derived from registers and mode inputs, all registered
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_timer_wake_enable <= 1'b0;
         o_stop_watchdog_off_b1 <= 1'b0;
         o_int_global <= 1'b0;
         o_wake_pin_sense_select <= 1'b0;
         o_wake_pin_wake_en <= 1'b0;
         o_gpio_cfg_ignored <= 1'b0;
         o_meas_enable <= 1'b0;
         o_wake_pin_pull_cfg <= 2'h0;
         o_gpio_wake_pull_cfg <= 2'h0;
         o_bus_fast_mode <= 1'b0;
         o_timer_wake <= 1'b0;
      end else begin
         o_timer_wake_enable <= internal_wake_ctrl[B_TIMER_WAKE];
         o_stop_watchdog_off_b1 <= internal_wake_ctrl[B_STOP_WD_OFF];
         o_int_global <= external_wake_ctrl[B_INT_GLOBAL];
         o_wake_pin_sense_select <= sense;
         o_wake_pin_wake_en <= external_wake_ctrl[B_WAKE_EN] && !sense;
         o_gpio_cfg_ignored <= sense && !i_fail_output;
         o_meas_enable <= sense && i_normal_mode;
         o_wake_pin_pull_cfg <= wake_pull_ctrl[B_WAKE_PULL +: 2];
         o_gpio_wake_pull_cfg <= i_gpio_is_wake ? wake_pull_ctrl[B_GPIO_PULL +: 2] : 2'h0;
         o_bus_fast_mode <= bus_fast_mode_ctrl[B_FAST];
         o_timer_wake <= cycle_start && internal_wake_ctrl[B_TIMER_WAKE];
      end
   end

   // Level status held at zero while the pin senses voltage
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wake_pin_level <= 1'b0;
         o_gpio_pin_level <= 1'b0;
      end else if (sense) begin
         o_wake_pin_level <= 1'b0;
         o_gpio_pin_level <= 1'b0;
      end else begin
         o_wake_pin_level <= i_wake_pin_level;
         o_gpio_pin_level <= i_gpio_pin_level;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq_out_n <= 1'b1;
      end else begin
         o_irq_out_n <= !(i_wake_event || (external_wake_ctrl[B_INT_GLOBAL] && i_status_event));
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_timer_write;
      wr_tmr && wr_data[6:4] != ON_RSVD;
   endsequence

   sequence s_timer_applied;
      ##1 (cyclic_timer_ctrl == (wr_data & MASK_TIMER)) && timer_cfg_stb;
   endsequence

   property p_reserved_zero;
      (internal_wake_ctrl & ~MASK_INT_WAKE) == 8'h00 && (external_wake_ctrl & ~MASK_EXT_WAKE) == 8'h00
         && (wake_pull_ctrl & ~MASK_PULL) == 8'h00 && (cyclic_timer_ctrl & ~MASK_TIMER) == 8'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit not zero");

   property p_stop_clear;
      i_stop_to_normal && !wr_int |=> !internal_wake_ctrl[B_STOP_WD_OFF] ##1 !o_stop_watchdog_off_b1;
   endproperty
   a_stop_clear: assert property (p_stop_clear) else $error("stop watchdog bit not cleared");

   property p_sense_refused;
      wr_ext && wr_data[B_SENSE] && i_fail_output && !i_failsafe_entry |=> o_spi_fail && $stable(external_wake_ctrl);
   endproperty
   a_sense_refused: assert property (p_sense_refused) else $error("sense set while fail output active");

   property p_failsafe_force;
      i_failsafe_entry && !sense |=> external_wake_ctrl[6] == 1'b0 && external_wake_ctrl[4:0] == 5'h01;
   endproperty
   a_failsafe_force: assert property (p_failsafe_force) else $error("fail-safe pattern not forced");

   property p_failsafe_sense;
      i_failsafe_entry && sense |=> $stable(external_wake_ctrl) ##1 !o_wake_pin_wake_en;
   endproperty
   a_failsafe_sense: assert property (p_failsafe_sense) else $error("wake pin armed while sensing");

   property p_level_held;
      sense [*2] |-> !o_wake_pin_level && !o_gpio_pin_level;
   endproperty
   a_level_held: assert property (p_level_held) else $error("level status updated while sensing");

   property p_irq_wake;
      i_wake_event |=> !o_irq_out_n;
   endproperty
   a_irq_wake: assert property (p_irq_wake) else $error("wake event did not assert interrupt");

   property p_irq_scope;
      !external_wake_ctrl[B_INT_GLOBAL] && !i_wake_event |=> o_irq_out_n;
   endproperty
   a_irq_scope: assert property (p_irq_scope) else $error("interrupt outside wake scope");

   property p_timer_apply;
      s_timer_write |-> s_timer_applied;
   endproperty
   a_timer_apply: assert property (p_timer_apply) else $error("timer write not applied");

   property p_timer_rsvd;
      wr_tmr && wr_data[6:4] == ON_RSVD |=> $stable(cyclic_timer_ctrl) && !timer_cfg_stb;
   endproperty
   a_timer_rsvd: assert property (p_timer_rsvd) else $error("reserved on-time code accepted");

   property p_wake_en_gate;
      sense |=> !o_wake_pin_wake_en;
   endproperty
   a_wake_en_gate: assert property (p_wake_en_gate) else $error("wake pin enabled while sensing");

endmodule : wcc_ctrl

`default_nettype wire

//--- src/wcc_pkg.sv
// Constants, codes and lookups shared by the wake and cyclic timer control block.
// Assumes a single 10 MHz system clock.
`default_nettype none

package wcc_pkg;

   // Clock rate and timer tick
   localparam int CLK_KHZ = 10000;
   localparam int TICK_US = 100;
   localparam int TICK_CYCLES = (TICK_US * CLK_KHZ + 999) / 1000;

   // Serial frame: 1 direction bit, 7 address bits, 8 data bits
   localparam int SPI_ADDR_BITS = 8;
   localparam int SPI_FRAME_BITS = 16;

   // Register addresses
   localparam logic [6:0] ADDR_INT_WAKE = 7'h06;
   localparam logic [6:0] ADDR_EXT_WAKE = 7'h07;
   localparam logic [6:0] ADDR_PULL = 7'h08;
   localparam logic [6:0] ADDR_BUS_FAST = 7'h0B;
   localparam logic [6:0] ADDR_TIMER = 7'h0C;

   // Writable bits per register; everything else reads zero
   localparam logic [7:0] MASK_INT_WAKE = 8'h44;
   localparam logic [7:0] MASK_EXT_WAKE = 8'hA1;
   localparam logic [7:0] MASK_PULL = 8'hC3;
   localparam logic [7:0] MASK_BUS_FAST = 8'h10;
   localparam logic [7:0] MASK_TIMER = 8'h7F;

   // Reset values
   localparam logic [7:0] RST_INT_WAKE = 8'h00;
   localparam logic [7:0] RST_EXT_WAKE = 8'h01;
   localparam logic [7:0] RST_PULL = 8'h00;
   localparam logic [7:0] RST_BUS_FAST = 8'h00;
   localparam logic [7:0] RST_TIMER = 8'h00;

   // Field positions
   localparam int B_TIMER_WAKE = 6;
   localparam int B_STOP_WD_OFF = 2;
   localparam int B_INT_GLOBAL = 7;
   localparam int B_SENSE = 5;
   localparam int B_WAKE_EN = 0;
   localparam int B_FAST = 4;
   localparam int B_GPIO_PULL = 6;
   localparam int B_WAKE_PULL = 0;
   localparam int B_ON_TIME = 4;
   localparam int B_PERIOD = 0;

   // Fail-safe pattern x0x0 0001: keep bits 7 and 5, force the rest
   localparam logic [7:0] FAILSAFE_KEEP = 8'hA0;
   localparam logic [7:0] FAILSAFE_SET = 8'h01;

   // On-time codes
   localparam logic [2:0] ON_OFF_LOW = 3'h0;
   localparam logic [2:0] ON_OFF_HIGH = 3'h6;
   localparam logic [2:0] ON_RSVD = 3'h7;

   typedef enum logic [1:0] {
      WCC_T_IDLE = 2'b00,
      WCC_T_ON = 2'b01,
      WCC_T_OFF = 2'b11
   } wcc_tstate_e;

   // On-time in 0.1 ms ticks: 0.1, 0.3, 1.0, 10, 20 ms
   function automatic logic [23:0] wcc_on_ticks(input logic [2:0] code);
      case (code)
         3'h1: wcc_on_ticks = 24'h000001;
         3'h2: wcc_on_ticks = 24'h000003;
         3'h3: wcc_on_ticks = 24'h00000A;
         3'h4: wcc_on_ticks = 24'h000064;
         3'h5: wcc_on_ticks = 24'h0000C8;
         default: wcc_on_ticks = 24'h000000;
      endcase
   endfunction : wcc_on_ticks

   // Period in 0.1 ms ticks: 10 ms up to 1000 s
   function automatic logic [23:0] wcc_per_ticks(input logic [3:0] code);
      case (code)
         4'h0: wcc_per_ticks = 24'h000064;
         4'h1: wcc_per_ticks = 24'h0000C8;
         4'h2: wcc_per_ticks = 24'h0001F4;
         4'h3: wcc_per_ticks = 24'h0003E8;
         4'h4: wcc_per_ticks = 24'h0007D0;
         4'h5: wcc_per_ticks = 24'h001388;
         4'h6: wcc_per_ticks = 24'h002710;
         4'h7: wcc_per_ticks = 24'h004E20;
         4'h8: wcc_per_ticks = 24'h00C350;
         4'h9: wcc_per_ticks = 24'h0186A0;
         4'hA: wcc_per_ticks = 24'h030D40;
         4'hB: wcc_per_ticks = 24'h07A120;
         4'hC: wcc_per_ticks = 24'h0F4240;
         4'hD: wcc_per_ticks = 24'h1E8480;
         4'hE: wcc_per_ticks = 24'h4C4B40;
         default: wcc_per_ticks = 24'h989680;
      endcase
   endfunction : wcc_per_ticks

endpackage : wcc_pkg

`default_nettype wire

//--- src/wcc_spi.sv
// Serial register port slave: chip select low frame, data taken on rising clock.
// Assumes the serial clock is at most one eighth of i_clk.
`default_nettype none

module wcc_spi
   import wcc_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_csn,
   input wire logic i_sdi,
   input wire logic [7:0] i_rd_data,
   output logic o_sdo,
   output logic o_sdo_oe,
   output logic [6:0] o_addr,
   output logic o_wr_stb,
   output logic [7:0] o_wr_data
);

   logic [2:0] sclk_s;
   logic [2:0] csn_s;
   logic [2:0] sdi_s;
   logic sclk_f;
   logic sclk_q;
   logic csn_f;
   logic csn_q;
   logic is_write;
   logic [4:0] cnt;
   logic [15:0] sh;
   logic [6:0] out_sh;

   wire sclk_rise = sclk_f & ~sclk_q;
   wire sclk_fall = ~sclk_f & sclk_q;
   wire csn_rise = csn_f & ~csn_q;

   // Clock and chip select levels count only when the last two stages agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_s <= 3'h0;
         csn_s <= 3'h7;
         sdi_s <= 3'h0;
         sclk_f <= 1'b0;
         csn_f <= 1'b1;
         sclk_q <= 1'b0;
         csn_q <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[1:0], i_sclk};
         csn_s <= {csn_s[1:0], i_csn};
         sdi_s <= {sdi_s[1:0], i_sdi};
         if (sclk_s[1] == sclk_s[2]) sclk_f <= sclk_s[2];
         if (csn_s[1] == csn_s[2]) csn_f <= csn_s[2];
         sclk_q <= sclk_f;
         csn_q <= csn_f;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 5'h00;
         sh <= 16'h0000;
         o_addr <= 7'h00;
         is_write <= 1'b0;
      end else if (csn_f) begin
         cnt <= 5'h00;
      end else if (sclk_rise) begin
         sh <= {sh[14:0], sdi_s[2]};
         if (cnt != 5'h1F) cnt <= cnt + 5'h01;
         if (cnt == 5'(SPI_ADDR_BITS - 1)) begin
            o_addr <= {sh[5:0], sdi_s[2]};
            is_write <= sh[6];
         end
      end
   end

   // Writes land only at chip select release of a whole frame
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_wr_stb <= 1'b0;
         o_wr_data <= 8'h00;
      end else begin
         o_wr_stb <= csn_rise && is_write && cnt == 5'(SPI_FRAME_BITS);
         if (csn_rise) o_wr_data <= sh[7:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_sdo <= 1'b0;
         out_sh <= 7'h00;
      end else if (csn_f) begin
         o_sdo <= 1'b0;
         out_sh <= 7'h00;
      end else if (sclk_fall) begin
         if (cnt == 5'(SPI_ADDR_BITS)) begin
            o_sdo <= i_rd_data[7];
            out_sh <= i_rd_data[6:0];
         end else begin
            o_sdo <= out_sh[6];
            out_sh <= {out_sh[5:0], 1'b0};
         end
      end
   end

   assign o_sdo_oe = ~csn_f;

endmodule : wcc_spi

`default_nettype wire

//--- src/wcc_timer.sv
// Cyclic timer: drives the high-side output for the on-time of each period.
// Assumes i_cfg_stb pulses whenever a new configuration is written.
`default_nettype none

module wcc_timer
   import wcc_pkg::*;
#(
   parameter int TICK_CNT = TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [2:0] i_on_code,
   input wire logic [3:0] i_per_code,
   input wire logic i_cfg_stb,
   output logic o_high_side_out,
   output logic o_cycle_start,
   output logic o_running
);

   wcc_tstate_e state;
   logic [15:0] pre;
   logic [23:0] ptick;

   wire run_code = i_on_code != ON_OFF_LOW && i_on_code != ON_OFF_HIGH && i_on_code != ON_RSVD;
   wire tick = pre == 16'(TICK_CNT - 1);
   wire [23:0] ptick_inc = ptick + 24'h000001;

   // A fresh configuration restarts the cycle at once
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state <= WCC_T_IDLE;
         pre <= 16'h0000;
         ptick <= 24'h000000;
         o_cycle_start <= 1'b0;
      end else begin
         o_cycle_start <= 1'b0;
         pre <= tick ? 16'h0000 : pre + 16'h0001;
         if (!run_code) begin
            state <= WCC_T_IDLE;
         end else if (state == WCC_T_IDLE || i_cfg_stb) begin
            state <= WCC_T_ON;
            pre <= 16'h0000;
            ptick <= 24'h000000;
            o_cycle_start <= 1'b1;
         end else if (tick) begin
            ptick <= ptick_inc;
            if (ptick_inc == wcc_per_ticks(i_per_code)) begin
               state <= WCC_T_ON;
               ptick <= 24'h000000;
               o_cycle_start <= 1'b1;
            end else if (ptick_inc == wcc_on_ticks(i_on_code)) begin
               state <= WCC_T_OFF;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_high_side_out <= 1'b0;
      end else if (!run_code) begin
         o_high_side_out <= i_on_code == ON_OFF_HIGH;
      end else begin
         o_high_side_out <= state != WCC_T_OFF;
      end
   end

   assign o_running = state != WCC_T_IDLE;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_off_low;
      (i_on_code == ON_OFF_LOW) [*2] |-> !o_high_side_out;
   endproperty
   a_off_low: assert property (p_off_low) else $error("high-side not low for off code");

   property p_off_high;
      (i_on_code == ON_OFF_HIGH) [*2] |-> o_high_side_out && !o_running;
   endproperty
   a_off_high: assert property (p_off_high) else $error("high-side not high for hold code");

endmodule : wcc_timer

`default_nettype wire

//--- test/wcc_ctrl_tb.sv
// Bench for wcc_ctrl: serial reads and writes, mode events, timer shape.
// Assumes TICK_CNT of 4, so one 0.1 ms tick lasts 4 clocks.
`default_nettype none
`define chk(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module wcc_ctrl_tb
   import wcc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 4;
   localparam logic [6:0] AD [6] = '{7'h06, 7'h07, 7'h08, 7'h0B, 7'h0C, 7'h0C};
   localparam logic [7:0] RV [5] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] WD [6] = '{8'hFF, 8'hDE, 8'hFF, 8'hFF, 8'hF5, 8'h8F};
   localparam logic [7:0] EX [6] = '{8'h44, 8'h80, 8'hC3, 8'h10, 8'h00, 8'h0F};
   logic clk, rst, sclk, csn, sdi, fo, s2n, fse, nm, wev, sev, wpl, gpl, giw;
   logic sdo, oe, twe, swd, ig, ss, wen, gci, me, wl, gl, irqn, fm, sf, hs, tw, tr;
   logic [1:0] wpp, gpp;
   logic [7:0] q;
   logic oe_q;
   int n_fail = 0, checks_done = 0, n_sf = 0, n_tw = 0;
   wcc_ctrl #(.TICK_CNT(TK)) i_wcc_ctrl (.i_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
      .o_sdo(sdo), .o_sdo_oe(oe), .i_fail_output(fo), .i_stop_to_normal(s2n), .i_failsafe_entry(fse),
      .i_normal_mode(nm), .i_wake_event(wev), .i_status_event(sev), .i_wake_pin_level(wpl),
      .i_gpio_pin_level(gpl), .i_gpio_is_wake(giw), .o_timer_wake_enable(twe), .o_stop_watchdog_off_b1(swd),
      .o_int_global(ig), .o_wake_pin_sense_select(ss), .o_wake_pin_wake_en(wen), .o_gpio_cfg_ignored(gci),
      .o_meas_enable(me), .o_wake_pin_level(wl), .o_gpio_pin_level(gl), .o_irq_out_n(irqn),
      .o_wake_pin_pull_cfg(wpp), .o_gpio_wake_pull_cfg(gpp), .o_bus_fast_mode(fm), .o_spi_fail(sf),
      .o_high_side_out(hs), .o_timer_wake(tw), .o_timer_running(tr));
   // Each serial level lasts 6 clocks, above the 4 the synchronisers need
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      logic [15:0] f;
      f = {w, a, d};
      csn = 1'b0;
      repeat (6) @(negedge clk);
      for (int i = 15; i >= 0; i--) begin
         sdi = f[i];
         repeat (6) @(negedge clk);
         if (i < 8) q[i] = sdo;
         if (i == 0) oe_q = oe;
         sclk = 1'b1;
         repeat (6) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (6) @(negedge clk);
      csn = 1'b1;
      repeat (10) @(negedge clk);
   endtask : xfer
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      `chk("read data", e, q)
      `chk("sdo enable", 2'b10, {oe_q, oe})
   endtask : rd
   task automatic till(input logic v, inout int n);
      while (hs !== v && n < 2000) begin
         @(negedge clk);
         n++;
      end
   endtask : till
   // Skips a partial pulse first, then times one whole cycle
   task automatic span(input int hi_e, input int per_e);
      int n;
      int p;
      n = 0;
      till(1'b0, n);
      till(1'b1, n);
      n = 0;
      till(1'b0, n);
      p = n;
      till(1'b1, p);
      `chk("on time", hi_e, n)
      `chk("period", per_e, p)
   endtask : span
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      if (sf === 1'b1) n_sf++;
      if (tw === 1'b1) n_tw++;
   end
   initial begin
      repeat (40000) @(negedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      {rst, csn} = 2'b11;
      {sclk, sdi, fo, s2n, fse, nm, wev, sev, wpl, gpl, giw} = '0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      `chk("wake enable", 1'b1, wen)
      for (int i = 0; i < 5; i++) rd(AD[i], RV[i]);
      giw = 1'b1;
      for (int i = 0; i < 6; i++) begin
         xfer(1'b1, AD[i], WD[i]);
         rd(AD[i], EX[i]);
      end
      `chk("timer wake en", 1'b1, twe)
      `chk("stop wd off", 1'b1, swd)
      `chk("int global", 1'b1, ig)
      `chk("fast mode", 1'b1, fm)
      `chk("wake enable", 1'b0, wen)
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, 7'h08, {c[1:0], 4'h0, c[1:0]});
         `chk("wake pull", c[1:0], wpp)
         `chk("gpio pull", c[1:0], gpp)
      end
      giw = 1'b0;
      repeat (2) @(negedge clk);
      `chk("gpio pull", 2'h0, gpp)
      s2n = 1'b1;
      @(negedge clk);
      s2n = 1'b0;
      repeat (2) @(negedge clk);
      `chk("stop wd off", 1'b0, swd)
      rd(7'h06, 8'h40);
      sev = 1'b1;
      repeat (2) @(negedge clk);
      `chk("irq", 1'b0, irqn)
      xfer(1'b1, 7'h07, 8'h00);
      `chk("irq", 1'b1, irqn)
      wev = 1'b1;
      repeat (2) @(negedge clk);
      `chk("irq", 1'b0, irqn)
      {wev, sev, fo, nm, wpl, gpl} = 6'h2F;
      xfer(1'b1, 7'h07, 8'hA1);
      `chk("spi fail", 1, n_sf)
      rd(7'h07, 8'h00);
      fo = 1'b0;
      `chk("levels", 2'b11, {wl, gl})
      xfer(1'b1, 7'h07, 8'h21);
      `chk("sense", 1'b1, ss)
      `chk("wake enable", 1'b0, wen)
      `chk("gpio ignored", 1'b1, gci)
      `chk("measure", 1'b1, me)
      `chk("levels", 2'b00, {wl, gl})
      for (int k = 0; k < 2; k++) begin
         fse = 1'b1;
         @(negedge clk);
         fse = 1'b0;
         repeat (2) @(negedge clk);
         rd(7'h07, k ? 8'h81 : 8'h21);
         `chk("wake enable", k[0], wen)
         xfer(1'b1, 7'h07, 8'h80);
      end
      xfer(1'b1, 7'h0C, 8'h60);
      `chk("high side", 2'b10, {hs, tr})
      xfer(1'b1, 7'h0C, 8'h00);
      `chk("high side", 1'b0, hs)
      xfer(1'b1, 7'h0C, 8'h10);
      span(1 * TK, 100 * TK);
      xfer(1'b1, 7'h0C, 8'h21);
      span(3 * TK, 200 * TK);
      `chk("timer wake", 1'b1, n_tw > 0)
      stop_test();
   end
endmodule : wcc_ctrl_tb
`default_nettype wire
